// ---- rtl/psalu_regs.vh ----
// opcode encodings, lane geometry and latency constants for the packed simd alu
`ifndef PSALU_REGS_VH
`define PSALU_REGS_VH
// operation codes
`define PSALU_OP_W            5
`define PSALU_OP_NOP          5'h00
`define PSALU_OP_ADD_B_WRAP   5'h01
`define PSALU_OP_ADD_W_WRAP   5'h02
`define PSALU_OP_ADD_D_WRAP   5'h03
`define PSALU_OP_ADD_B_SSAT   5'h04
`define PSALU_OP_ADD_W_SSAT   5'h05
`define PSALU_OP_ADD_B_USAT   5'h06
`define PSALU_OP_ADD_W_USAT   5'h07
`define PSALU_OP_SUB_B_WRAP   5'h08
`define PSALU_OP_SUB_W_WRAP   5'h09
`define PSALU_OP_SUB_D_WRAP   5'h0A
`define PSALU_OP_SUB_B_SSAT   5'h0B
`define PSALU_OP_SUB_W_SSAT   5'h0C
`define PSALU_OP_SUB_B_USAT   5'h0D
`define PSALU_OP_SUB_W_USAT   5'h0E
`define PSALU_OP_MUL_W_HIGH   5'h0F
`define PSALU_OP_MUL_W_LOW    5'h10
`define PSALU_OP_MUL_ADD_WD   5'h11
`define PSALU_OP_MOVE_DWORD   5'h12
`define PSALU_OP_MOVE_QWORD   5'h13
// saturation mode codes for the core's opcode decode
`define PSALU_SAT_WRAP        2'h0
`define PSALU_SAT_SIGNED      2'h1
`define PSALU_SAT_UNSIGNED    2'h2
// saturation limits
`define PSALU_SBYTE_MAX       8'h7F
`define PSALU_SBYTE_MIN       8'h80
`define PSALU_UBYTE_MAX       8'hFF
`define PSALU_UBYTE_MIN       8'h00
// geometry and latency
`define PSALU_DATA_W          64
`define PSALU_BYTE_LANES      8
`define PSALU_LATENCY         1
`endif

// ---- rtl/psalu_byte_lane.v ----
// one byte slice of the packed adder with carry chaining and signed overflow detection
`timescale 1ns/1ps
`include "psalu_regs.vh"
module psalu_byte_lane
(
    // operands
    input  wire [7:0] a,
    input  wire [7:0] b,
    input  wire       sub,
    // carry chain: chain picks chained carry or fresh lane start
    input  wire       chain,
    input  wire       cin,
    // raw result and carry out of this slice
    output wire [7:0] sum,
    output wire       cout,
    output wire       ovf
);
    wire [7:0] b_eff;   // inverted operand for subtract
    wire       c0;      // carry into bit 0
    wire [8:0] total;   // nine-bit sum
    wire [7:0] low7;    // carry into top bit probe
    assign b_eff = sub ? ~b : b;
    // fresh element starts with carry equal to sub (two's complement)
    assign c0    = chain ? cin : sub;
    assign total = {1'b0, a} + {1'b0, b_eff} + {8'h00, c0};
    assign sum   = total[7:0];
    assign cout  = total[8];
    // signed overflow when carry into msb differs from carry out
    assign low7  = {1'b0, a[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, c0};
    assign ovf   = low7[7] ^ total[8];
endmodule // psalu_byte_lane

// ---- rtl/psalu_core.v ----
// packed integer simd datapath: add, subtract, multiply, multiply-add, moves
// Notes on behaviour
// RULE_01: low element at lowest address, little endian
// RULE_02: wraparound keeps only low element bits
// RULE_03: signed words clamp to 7FFF and 8000
// RULE_04: signed bytes clamp to 80 and 7F
// RULE_05: unsigned clamp to all ones or zero
// RULE_06: no flags or exceptions on overflow
// RULE_07: one operation on all lanes at once
// RULE_08: doubleword move transfers thirty-two bits
// RULE_09: quadword move transfers sixty-four bits
// RULE_10: plain add/sub wrap on bytes, words, dwords
// RULE_11: signed saturating add/sub, bytes and words
// RULE_12: unsigned saturating add/sub, bytes and words
// RULE_13: signed word multiply keeps high or low
// RULE_14: multiply-add sums word product pairs to dwords
// RULE_15: no carry or saturation crosses lanes
`timescale 1ns/1ps
`include "psalu_regs.vh"
module psalu_core
#(
    parameter DATA_W = `PSALU_DATA_W
)
(
    // clock and reset
    input  wire                  clk,
    input  wire                  rst_b,
    // issue from instruction decode
    input  wire                  issue_valid,
    input  wire [`PSALU_OP_W-1:0] issue_op,
    input  wire [DATA_W-1:0]     src_dst,
    input  wire [DATA_W-1:0]     src_other,
    // memory image in address order, byte 0 at lowest address
    input  wire [DATA_W-1:0]     mem_bytes_in,
    input  wire                  use_mem,
    // result to register file
    output reg                   result_valid,
    output reg  [DATA_W-1:0]     result,
    // result as memory image, byte 0 at lowest address
    output reg  [DATA_W-1:0]     mem_bytes_out
);
    localparam LANES = `PSALU_BYTE_LANES;
    // element geometry: a word spans bytes 2i..2i+1, a dword bytes 4i..4i+3;
    // every element result depends only on its own bytes, so one decode serves
    // all lanes and the whole 64-bit operand settles in a single cycle

    // decode fields
    reg        dec_sub;       // subtract
    reg  [1:0] dec_size;      // 0 byte, 1 word, 2 dword
    reg  [1:0] dec_sat;       // saturation mode
    reg        dec_add_path;  // result from adder
    integer    k;             // lane index for the saturation loop
    integer    m;             // lane index for the product loop

    // operand b, optionally taken from memory image
    wire [DATA_W-1:0] opnd_b;
    wire [DATA_W-1:0] mem_as_reg;
    wire [DATA_W-1:0] reg_as_mem;

    // adder slice wires
    wire [LANES-1:0]  lane_cout;
    wire [LANES-1:0]  lane_ovf;
    wire [LANES-1:0]  lane_chain;
    wire [DATA_W-1:0] raw_sum;

    // saturated and final values
    reg  [DATA_W-1:0] add_res;
    reg  [DATA_W-1:0] mul_res;
    reg  [DATA_W-1:0] next_result;
    reg               top_ovf;
    reg               top_cout;
    reg               top_msb;
    reg  [31:0]       prod [0:3];
    reg  [31:0]       mul_lo_pair;
    reg  [31:0]       mul_hi_pair;

    // byte reversal is identity here: register bit 8i..8i+7 is address i
    // the store image follows next_result, so both outputs load together
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1)
        begin : g_bytes
            assign mem_as_reg[8*g+7:8*g] = mem_bytes_in[8*g+7:8*g]; // RULE_01
            assign reg_as_mem[8*g+7:8*g] = next_result[8*g+7:8*g];  // RULE_01
        end
    endgenerate

    assign opnd_b = use_mem ? mem_as_reg : src_other;

    // carry chains only inside an element; lane boundaries restart carry
    // a restarted lane takes carry-in equal to sub, which completes the
    // two's complement of the second operand for that element alone
    generate
        for (g = 0; g < LANES; g = g + 1)
        begin : g_lane
            wire cin_w;
            if (g == 0)
            begin : g_c0
                assign cin_w = 1'b0;
            end
            else
            begin : g_cn
                assign cin_w = lane_cout[g-1];
            end
            // chaining: word joins odd bytes, dword joins all but 0 and 4
            assign lane_chain[g] = (g % 2 == 1) ? (dec_size != 2'h0) :
                                   ((g % 4 == 2) ? (dec_size == 2'h2) : 1'b0); // RULE_15
            // one adder slice per byte lane
            psalu_byte_lane u_lane
            (
                .a    (src_dst[8*g+7:8*g]),
                .b    (opnd_b[8*g+7:8*g]),
                .sub  (dec_sub),
                .chain(lane_chain[g]),
                .cin  (cin_w),
                .sum  (raw_sum[8*g+7:8*g]),
                .cout (lane_cout[g]),
                .ovf  (lane_ovf[g])
            ); // RULE_07
        end
    endgenerate

    // opcode decode
    // byte size, wraparound and add are the defaults, so each branch but the byte wraparound add names only
    // what differs; every code outside add/sub leaves the adder result unused
    always @*
    begin
        dec_sub      = 1'b0;
        dec_size     = 2'h0;
        dec_sat      = `PSALU_SAT_WRAP;
        dec_add_path = 1'b1;
        case (issue_op)
            // wraparound adds
            `PSALU_OP_ADD_B_WRAP : dec_size = 2'h0; // RULE_10
            `PSALU_OP_ADD_W_WRAP : dec_size = 2'h1; // RULE_10
            `PSALU_OP_ADD_D_WRAP : dec_size = 2'h2; // RULE_10
            // saturating adds
            `PSALU_OP_ADD_B_SSAT : dec_sat  = `PSALU_SAT_SIGNED; // RULE_11
            `PSALU_OP_ADD_W_SSAT :
            begin
                dec_size = 2'h1;
                dec_sat  = `PSALU_SAT_SIGNED; // RULE_11
            end
            `PSALU_OP_ADD_B_USAT : dec_sat  = `PSALU_SAT_UNSIGNED; // RULE_12
            `PSALU_OP_ADD_W_USAT :
            begin
                dec_size = 2'h1;
                dec_sat  = `PSALU_SAT_UNSIGNED; // RULE_12
            end
            // wraparound subtracts
            `PSALU_OP_SUB_B_WRAP : dec_sub  = 1'b1; // RULE_10
            `PSALU_OP_SUB_W_WRAP :
            begin
                dec_sub  = 1'b1;
                dec_size = 2'h1; // RULE_10
            end
            `PSALU_OP_SUB_D_WRAP :
            begin
                dec_sub  = 1'b1;
                dec_size = 2'h2; // RULE_10
            end
            // saturating subtracts
            `PSALU_OP_SUB_B_SSAT :
            begin
                dec_sub  = 1'b1;
                dec_sat  = `PSALU_SAT_SIGNED; // RULE_11
            end
            `PSALU_OP_SUB_W_SSAT :
            begin
                dec_sub  = 1'b1;
                dec_size = 2'h1;
                dec_sat  = `PSALU_SAT_SIGNED; // RULE_11
            end
            `PSALU_OP_SUB_B_USAT :
            begin
                dec_sub  = 1'b1;
                dec_sat  = `PSALU_SAT_UNSIGNED; // RULE_12
            end
            `PSALU_OP_SUB_W_USAT :
            begin
                dec_sub  = 1'b1;
                dec_size = 2'h1;
                dec_sat  = `PSALU_SAT_UNSIGNED; // RULE_12
            end
            default              : dec_add_path = 1'b0;
        endcase
    end

    // per element saturation; evaluated at each element's top byte
    // dword elements never saturate, so only byte and word sizes are examined;
    // a clamp overwrites the whole element, low byte included
    always @*
    begin
        add_res  = raw_sum; // RULE_02
        top_ovf  = 1'b0;
        top_cout = 1'b0;
        top_msb  = 1'b0;
        for (k = 0; k < LANES; k = k + 1)
        begin
            // top byte of element: byte mode every byte, word mode odd bytes
            if ((dec_size == 2'h0) || ((dec_size == 2'h1) && (k % 2 == 1)))
            begin
                top_ovf  = lane_ovf[k];
                top_cout = lane_cout[k];
                top_msb  = raw_sum[8*k+7];
                // signed clamp only when the top byte reports overflow
                if (dec_sat == `PSALU_SAT_SIGNED && top_ovf)
                begin
                    // overflow sign is opposite of wrapped msb
                    if (dec_size == 2'h0)
                        add_res[8*k+7 -: 8] = top_msb ? `PSALU_SBYTE_MAX
                                                      : `PSALU_SBYTE_MIN; // RULE_04
                    else
                        add_res[8*k+7 -: 16] = top_msb ? {`PSALU_SBYTE_MAX, `PSALU_UBYTE_MAX}
                                               : {`PSALU_SBYTE_MIN, `PSALU_UBYTE_MIN}; // RULE_03
                end
                else if (dec_sat == `PSALU_SAT_UNSIGNED)
                begin
                    // add overflows on carry; subtract underflows on no carry
                    if (!dec_sub && top_cout)
                    begin
                        if (dec_size == 2'h0)
                            add_res[8*k+7 -: 8] = `PSALU_UBYTE_MAX; // RULE_05
                        else
                            add_res[8*k+7 -: 16] = {`PSALU_UBYTE_MAX, `PSALU_UBYTE_MAX}; // RULE_05
                    end
                    else if (dec_sub && !top_cout)
                    begin
                        if (dec_size == 2'h0)
                            add_res[8*k+7 -: 8] = `PSALU_UBYTE_MIN; // RULE_05
                        else
                            add_res[8*k+7 -: 16] = {`PSALU_UBYTE_MIN, `PSALU_UBYTE_MIN}; // RULE_05
                    end
                end
            end
        end
    end

    // signed word products and pair sums
    // a product of two signed words always fits 32 bits; only the pair sum of
    // two most-negative squares overflows, and it wraps at 32 bits
    always @*
    begin
        for (m = 0; m < 4; m = m + 1)
            prod[m] = $signed(src_dst[16*m+15 -: 16]) * $signed(opnd_b[16*m+15 -: 16]);
        mul_lo_pair = prod[0] + prod[1]; // RULE_14
        mul_hi_pair = prod[2] + prod[3]; // RULE_14
        mul_res     = {DATA_W{1'b0}};
        // keep the high or low half of each word product
        for (m = 0; m < 4; m = m + 1)
        begin
            if (issue_op == `PSALU_OP_MUL_W_HIGH)
                mul_res[16*m+15 -: 16] = prod[m][31:16]; // RULE_13
            else
                mul_res[16*m+15 -: 16] = prod[m][15:0];  // RULE_13
        end
        // multiply-add replaces the halves with the two pair sums
        if (issue_op == `PSALU_OP_MUL_ADD_WD)
            mul_res = {mul_hi_pair, mul_lo_pair}; // RULE_14
    end

    // result select
    // undefined codes fall to the default branch and produce an all-zero result
    always @*
    begin
        next_result = {DATA_W{1'b0}};
        case (issue_op)
            `PSALU_OP_MUL_W_HIGH,
            `PSALU_OP_MUL_W_LOW,
            `PSALU_OP_MUL_ADD_WD : next_result = mul_res;
            // dword move zero extends into the upper half
            `PSALU_OP_MOVE_DWORD : next_result = {32'h0000_0000, opnd_b[31:0]}; // RULE_08
            `PSALU_OP_MOVE_QWORD : next_result = opnd_b; // RULE_09
            default              : next_result = dec_add_path ? add_res : {DATA_W{1'b0}};
        endcase
    end

    // one-cycle result register; no flag or exception outputs exist
    // a nop is never answered, an undefined code is answered with zero;
    // both load the selected value, so only an idle cycle keeps the result
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // outputs read zero while reset is held
            result_valid  <= 1'b0;
            result        <= {DATA_W{1'b0}};
            mem_bytes_out <= {DATA_W{1'b0}};
        end
        else
        begin
            // answer strobe lasts one cycle
            result_valid <= issue_valid && (issue_op != `PSALU_OP_NOP); // RULE_06
            // result and image load only on an issue edge
            if (issue_valid)
            begin
                result        <= next_result;
                mem_bytes_out <= reg_as_mem; // RULE_01
            end
        end
    end
endmodule // psalu_core

// ---- tb/psalu_core_monitor.sv ----
// port-level concurrent checks for the packed simd alu core
`timescale 1ns/1ps
`include "psalu_regs.vh"
module psalu_core_monitor
#(
    parameter DATA_W = 64
)
(
    // clock and reset
    input wire logic                    clk,
    input wire logic                    rst_b,
    // issue side
    input wire logic                    issue_valid,
    input wire logic [`PSALU_OP_W-1:0]  issue_op,
    input wire logic [DATA_W-1:0]       src_dst,
    input wire logic [DATA_W-1:0]       src_other,
    input wire logic [DATA_W-1:0]       mem_bytes_in,
    input wire logic                    use_mem,
    // result side
    input wire logic                    result_valid,
    input wire logic [DATA_W-1:0]       result,
    input wire logic [DATA_W-1:0]       mem_bytes_out
);
    // second operand as the core selects it
    wire [DATA_W-1:0]  opb  = use_mem ? mem_bytes_in : src_other;
    wire [31:0]        blo  = opb[31:0];                       // low dword of operand b
    wire [31:0]        dsum = src_dst[31:0] + opb[31:0];       // low dword wrap sum
    wire [8:0]         usum = src_dst[7:0] + opb[7:0];         // low byte sum with carry
    wire               ucar = usum[8];                         // unsigned byte overflow
    wire [7:0]         ulow = usum[7:0];                       // truncated byte sum
    wire signed [31:0] p0   = $signed(src_dst[15:0]) * $signed(opb[15:0]);
    wire signed [31:0] p1   = $signed(src_dst[31:16]) * $signed(opb[31:16]);
    wire [15:0]        plo  = p0[15:0];                        // low half of lane 0 product
    wire [15:0]        phi  = p0[31:16];                       // high half of lane 0 product
    wire [31:0]        madd = p0 + p1;                         // low pair sum
    wire               real_op = issue_valid && (issue_op != `PSALU_OP_NOP); // answered issue

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // every issue but a nop answers one cycle later, nothing else does
    property p_answer; real_op |=> result_valid; endproperty
    a_answer: assert property (p_answer) else $error("no answer after issue");
    property p_quiet; !real_op |=> !result_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without issue");
    // memory image mirrors the register result
    property p_image; result_valid |-> mem_bytes_out == result; endproperty
    a_image: assert property (p_image) else $error("memory image differs");
    // dword wrap keeps only the low 32 bits
    property p_dwrap; issue_valid && issue_op == `PSALU_OP_ADD_D_WRAP
        |=> result[31:0] == $past(dsum); endproperty
    a_dwrap: assert property (p_dwrap) else $error("dword wrap sum wrong");
    // unsigned byte add clamps to all ones
    property p_usat; issue_valid && issue_op == `PSALU_OP_ADD_B_USAT
        |=> result[7:0] == ($past(ucar) ? 8'hFF : $past(ulow)); endproperty
    a_usat: assert property (p_usat) else $error("unsigned byte clamp wrong");
    property p_mlow; issue_valid && issue_op == `PSALU_OP_MUL_W_LOW
        |=> result[15:0] == $past(plo); endproperty
    a_mlow: assert property (p_mlow) else $error("low product wrong");
    property p_mhigh; issue_valid && issue_op == `PSALU_OP_MUL_W_HIGH
        |=> result[15:0] == $past(phi); endproperty
    a_mhigh: assert property (p_mhigh) else $error("high product wrong");
    property p_madd; issue_valid && issue_op == `PSALU_OP_MUL_ADD_WD
        |=> result[31:0] == $past(madd); endproperty
    a_madd: assert property (p_madd) else $error("pair sum wrong");
    property p_dmove; issue_valid && issue_op == `PSALU_OP_MOVE_DWORD
        |=> result == {32'h0, $past(blo)}; endproperty
    a_dmove: assert property (p_dmove) else $error("dword move wrong");
    property p_qmove; issue_valid && issue_op == `PSALU_OP_MOVE_QWORD
        |=> result == $past(opb); endproperty
    a_qmove: assert property (p_qmove) else $error("qword move wrong");

    // main scenarios reached
    c_usat: cover property (issue_valid && issue_op == `PSALU_OP_ADD_B_USAT && ucar);
    c_madd: cover property (issue_valid && issue_op == `PSALU_OP_MUL_ADD_WD);
    c_load: cover property (issue_valid && use_mem);
endmodule // psalu_core_monitor

bind psalu_core psalu_core_monitor #(.DATA_W(DATA_W)) i_mon (.clk(clk), .rst_b(rst_b),
    .issue_valid(issue_valid), .issue_op(issue_op), .src_dst(src_dst),
    .src_other(src_other), .mem_bytes_in(mem_bytes_in), .use_mem(use_mem),
    .result_valid(result_valid), .result(result), .mem_bytes_out(mem_bytes_out));

// ---- tb/psalu_mem_model.sv ----
// byte-addressed memory standing behind the core's load and store paths
`timescale 1ns/1ps
module psalu_mem_model
(
    // clock
    input  wire logic        clk,
    // store strobe and image
    input  wire logic        store,
    input  wire logic [63:0] wr_img,
    // load image
    output logic      [63:0] rd_img
);
    logic [7:0] mem [0:7];  // eight bytes from base upward

    // load: byte at base+i lands in bits 8i+7:8i
    always_comb
        for (int i = 0; i < 8; i++)
            rd_img[8*i +: 8] = mem[i];

    // store: lowest byte goes to the lowest address
    always @(posedge clk)
        if (store)
            for (int i = 0; i < 8; i++)
                mem[i] <= wr_img[8*i +: 8];
endmodule // psalu_mem_model

// ---- tb/tb_top.sv ----
// self-checking bench for the packed simd alu core
`timescale 1ns/1ps
`include "psalu_regs.vh"
module tb_top;
    logic        clk;            // core clock
    logic        rst_b;          // reset, active low
    logic        issue_valid;    // issue strobe
    logic [4:0]  issue_op;       // opcode
    logic [63:0] src_dst;        // first operand
    logic [63:0] src_other;      // second operand
    logic        use_mem;        // take memory image
    logic        store;          // write result to memory
    logic [63:0] mem_img;        // memory image to core
    logic        result_valid;   // answer strobe
    logic [63:0] result;         // register result
    logic [63:0] mem_bytes_out;  // result as memory image
    int          err_count;      // mismatches
    int          n_checks;       // comparisons
    // add/sub results for ops 01..0E on one operand pair
    localparam logic [63:0] ADDSUB_EXP [14] = '{
        64'h7F00_8101_0100_8000, 64'h8000_8101_0200_8100, 64'h8000_8101_0200_8100,
        64'h7F00_8101_0100_7F80, 64'h7FFF_8101_0200_7FFF, 64'h7FFF_8101_FFFF_80FF,
        64'h8000_8101_FFFF_8100, 64'h7FFE_7FFF_FD02_7E00, 64'h7FFE_7EFF_FC02_7E00,
        64'h7FFE_7EFF_FC02_7E00, 64'h7FFE_80FF_FD02_7E00, 64'h7FFE_8000_FC02_7E00,
        64'h7FFE_7F00_FD00_7E00, 64'h7FFE_7EFF_FC02_7E00};

    psalu_core i_dut (.clk(clk), .rst_b(rst_b), .issue_valid(issue_valid),
        .issue_op(issue_op), .src_dst(src_dst), .src_other(src_other),
        .mem_bytes_in(mem_img), .use_mem(use_mem), .result_valid(result_valid),
        .result(result), .mem_bytes_out(mem_bytes_out));
    psalu_mem_model i_mem (.clk(clk), .store(store), .wr_img(mem_bytes_out), .rd_img(mem_img));

    // 250 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // data compare
    task chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // flag compare
    task chk1(input string name, input logic exp, input logic got);
        chk(name, {63'h0, exp}, {63'h0, got});
    endtask

    // issue at a falling edge, judge one cycle later
    task run(input logic [4:0] op, input logic [63:0] a, input logic [63:0] b,
             input logic um, input logic [63:0] exp);
        issue_valid = 1'b1;
        issue_op = op;
        src_dst = a;
        src_other = b;
        use_mem = um;
        @(posedge clk);
        @(negedge clk);
        chk1("result_valid", 1'b1, result_valid);
        chk("result", exp, result);
    endtask

    // all add and subtract codes back to back
    task t_addsub;
        for (int i = 0; i < 14; i++)
            run(5'(i + 1), 64'h7FFF_8000_FF01_7F80, 64'h0001_0101_02FF_0180, 1'b0,
                ADDSUB_EXP[i]);
        $display("test addsub done");
    endtask

    // multiplies with extreme signed words
    task t_mul;
        run(`PSALU_OP_MUL_W_HIGH, 64'h8000_7FFF_FFFF_0003, 64'h8000_7FFF_0002_0004, 1'b0,
            64'h4000_3FFF_FFFF_0000);
        run(`PSALU_OP_MUL_W_LOW, 64'h8000_7FFF_FFFF_0003, 64'h8000_7FFF_0002_0004, 1'b0,
            64'h0000_0001_FFFE_000C);
        run(`PSALU_OP_MUL_ADD_WD, 64'h8000_7FFF_FFFF_0003, 64'h8000_7FFF_0002_0004, 1'b0,
            64'h7FFF_0001_0000_000A);
        $display("test mul done");
    endtask

    // moves through registers and memory
    task t_move;
        run(`PSALU_OP_MOVE_QWORD, 64'h0, 64'h0807_0605_0403_0201, 1'b0,
            64'h0807_0605_0403_0201);
        issue_valid = 1'b0;
        store = 1'b1;
        @(negedge clk);
        store = 1'b0;
        chk("lowest byte", 64'h01, {56'h0, i_mem.mem[0]});
        chk("highest byte", 64'h08, {56'h0, i_mem.mem[7]});
        run(`PSALU_OP_MOVE_DWORD, 64'h0, 64'h0, 1'b1, 64'h0000_0000_0403_0201);
        run(`PSALU_OP_MOVE_QWORD, 64'h0, 64'h0, 1'b1, 64'h0807_0605_0403_0201);
        run(`PSALU_OP_MOVE_DWORD, 64'h0, 64'hDEAD_BEEF_1234_5678, 1'b0,
            64'h0000_0000_1234_5678);
        $display("test move done");
    endtask

    // idle keeps the result, nop is silent and loads zero, undefined answers zero
    task t_refuse;
        issue_valid = 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk1("idle valid", 1'b0, result_valid);
        chk("idle result held", 64'h0000_0000_1234_5678, result);
        issue_valid = 1'b1;
        issue_op = `PSALU_OP_NOP;
        @(posedge clk);
        @(negedge clk);
        chk1("nop valid", 1'b0, result_valid);
        chk("nop result", 64'h0, result);
        run(`PSALU_OP_MOVE_DWORD, 64'h0, 64'h0000_0000_0000_00A5, 1'b0, 64'h0000_0000_0000_00A5);
        issue_op = 5'h1F;
        @(posedge clk);
        @(negedge clk);
        chk1("undefined valid", 1'b1, result_valid);
        chk("undefined result", 64'h0, result);
        issue_valid = 1'b0;
        $display("test refuse done");
    endtask

    // verdict and end of run
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // hang guard, far beyond the expected run
    initial
    begin
        #10000;
        err_count++;
        report_and_stop();
    end

    // main sequence
    initial
    begin
        {rst_b, issue_valid, use_mem, store} = 4'h0;
        {issue_op, src_dst, src_other} = '0;
        err_count = 0;
        n_checks = 0;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        t_addsub();
        t_mul();
        t_move();
        t_refuse();
        report_and_stop();
    end
endmodule // tb_top
